// file: fcd_defines.svh
// fcd_defines.svh: offsets, command codes and timing counts of the flash
// command host. Assumes a 100 MHz system clock.
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// widths of the flash pins
`define FCD_ADDR_W 20
`define FCD_DQ_W 16

// software register word indices, compared with avs_address_in[4:2]
`define FCD_REG_CTRL 3'h0
`define FCD_REG_ADDR 3'h1
`define FCD_REG_DATA 3'h2
`define FCD_REG_STAT 3'h3
`define FCD_REG_CFG 3'h4

// operation codes written to the control register
`define FCD_OP_READ 4'h0
`define FCD_OP_RESET 4'h1
`define FCD_OP_IDENT 4'h2
`define FCD_OP_PROG 4'h3
`define FCD_OP_BYP_ENTER 4'h4
`define FCD_OP_BYP_PROG 4'h5
`define FCD_OP_BYP_EXIT 4'h6
`define FCD_OP_CHIP_ERASE 4'h7
`define FCD_OP_SECT_ERASE 4'h8
`define FCD_OP_SUSPEND 4'h9
`define FCD_OP_RESUME 4'ha

// flash command bytes
`define FCD_CMD_RESET 8'hf0
`define FCD_CMD_UNLOCK1 8'haa
`define FCD_CMD_UNLOCK2 8'h55
`define FCD_CMD_IDENT 8'h90
`define FCD_CMD_PROGRAM 8'ha0
`define FCD_CMD_BYPASS 8'h20
`define FCD_CMD_BYP_EXIT2 8'h00
`define FCD_CMD_ERASE_SETUP 8'h80
`define FCD_CMD_CHIP 8'h10
`define FCD_CMD_SECTOR 8'h30
`define FCD_CMD_SUSPEND 8'hb0
`define FCD_CMD_RESUME 8'h30

// unlock addresses, word and byte mode
`define FCD_UA1_WORD 20'h00555
`define FCD_UA2_WORD 20'h002aa
`define FCD_UA1_BYTE 20'h00aaa
`define FCD_UA2_BYTE 20'h00555

// status bit positions within the data bus
`define FCD_POLL_BIT 7
`define FCD_TOGGLE_BIT 6
`define FCD_FAIL_BIT 5
`define FCD_WINDOW_BIT 3

// bus cycle timing
`define FCD_CLK_NS 10
`define FCD_WE_PULSE_NS 80
`define FCD_ACCESS_NS 90
`define FCD_WE_PULSE_CYC ((`FCD_WE_PULSE_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_ACCESS_CYC ((`FCD_ACCESS_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_SYNC_CYC 2

`endif

// file: fcd_pkg.sv
// fcd_pkg.sv: types shared by the flash command host modules.
// Assumes fcd_defines.svh is on the include path.
`include "fcd_defines.svh"

package fcd_pkg;

  // phase of one flash bus cycle
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SETUP,
    PH_PULSE,
    PH_HOLD
  } fcd_ph_t;

  // sequencer state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEQ,
    ST_POLL,
    ST_REPOLL,
    ST_FINAL,
    ST_ABORT
  } fcd_st_t;

  // one step of a command sequence
  typedef struct packed {
    logic valid;
    logic wr;
    logic [`FCD_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fcd_step_t;

endpackage : fcd_pkg

// file: fcd_sync.sv
// fcd_sync.sv: two flip-flop synchroniser for levels entering from pins.
// Assumes inputs are asynchronous to clk_sys_in.
`timescale 1ns/10ps

module fcd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fcd_sync_t;

  fcd_sync_t r_reg;
  fcd_sync_t r_next;

  // first stage feeds only the second stage
  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.s2;

endmodule : fcd_sync

// file: fcd_pin_cycle.sv
// fcd_pin_cycle.sv: runs one write or read cycle on the flash pins.
// Assumes dq_sync_in is the data bus already passed through two flops.
`timescale 1ns/10ps
`include "fcd_defines.svh"

module fcd_pin_cycle #(
  parameter int AW = `FCD_ADDR_W,
  parameter int DW = `FCD_DQ_W,
  parameter logic [7:0] PULSE_CYC = 8'(`FCD_WE_PULSE_CYC),
  parameter logic [7:0] READ_CYC = 8'(`FCD_ACCESS_CYC + `FCD_SYNC_CYC)
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // request from the sequencer
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] data_in,
  input wire logic [DW-1:0] dq_sync_in,
  output logic done_out,
  output logic [DW-1:0] rdata_out,
  // flash pins
  output logic [AW-1:0] flash_addr_out,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);

  typedef struct packed {
    fcd_pkg::fcd_ph_t ph;
    logic [7:0] cnt;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] dout;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic done;
    logic [DW-1:0] rdata;
  } fcd_pc_t;

  fcd_pc_t r_reg;
  fcd_pc_t r_next;

  // chip select falls before and rises after the write strobe, so the
  // write strobe edges are the ones the flash latches on
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.ph)
      fcd_pkg::PH_IDLE: begin
        if (start_in) begin
          r_next.ph = fcd_pkg::PH_SETUP;
          r_next.wr = write_in;
          r_next.addr = addr_in;
          r_next.dout = data_in;
          r_next.dq_oe = write_in;
          r_next.ce_n = 1'b0;
          r_next.oe_n = write_in; // read cycle opens output at once
        end
      end
      fcd_pkg::PH_SETUP: begin
        r_next.ph = fcd_pkg::PH_PULSE;
        r_next.we_n = !r_reg.wr; // address latched here
        r_next.cnt = r_reg.wr ? PULSE_CYC : READ_CYC;
      end
      fcd_pkg::PH_PULSE: begin
        if (r_reg.cnt <= 8'h01) begin
          r_next.ph = fcd_pkg::PH_HOLD;
          r_next.we_n = 1'b1; // data latched on this rise
          r_next.oe_n = 1'b1;
          if (!r_reg.wr) begin
            r_next.rdata = dq_sync_in;
          end
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      fcd_pkg::PH_HOLD: begin
        r_next.ph = fcd_pkg::PH_IDLE;
        r_next.ce_n = 1'b1;
        r_next.dq_oe = 1'b0;
        r_next.done = 1'b1;
      end
      default: begin
        r_next.ph = fcd_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r_reg <= '{ph: fcd_pkg::PH_IDLE, cnt: 8'h00, wr: 1'b0, addr: '0,
                 dout: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                 oe_n: 1'b1, done: 1'b0, rdata: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_out = r_reg.done;
  assign rdata_out = r_reg.rdata;
  assign flash_addr_out = r_reg.addr;
  assign flash_dq_out = r_reg.dout;
  assign flash_dq_oe_out = r_reg.dq_oe;
  assign flash_ce_n_out = r_reg.ce_n;
  assign flash_we_n_out = r_reg.we_n;
  assign flash_oe_n_out = r_reg.oe_n;

endmodule : fcd_pin_cycle

// file: fcd_flash_host.sv
// fcd_flash_host.sv: host controller that drives a parallel boot-sector
// flash through its pins and reports to software over Avalon-MM.
// Assumes one 100 MHz clock; flash pins are asynchronous to it.
//
// Overview of operation
// - all command sequence cycles are writes, except array or identity reads
// - one F0 write returns the flash to array reading
// - unlock is AA at 555 then 55 at 2AA, AAA/555 in byte mode
// - program is unlock, A0 at 555/AAA, then target and value
// - identity is unlock, 90 at 555/AAA, then a read cycle
// - erase is unlock, 80, unlock, then 10 chip or 30 at sector
// - bypass entry is unlock plus 20; bypass program is A0 then data
// - bypass exit is 90 then 00 at any address
// - B0 suspends sector erase; reads, programs, identity still allowed
// - host polls at program target or inside an erasing sector
// - host reads again after poll bit turns true for all bits
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "fcd_defines.svh"

module fcd_flash_host #(
  parameter int AW = `FCD_ADDR_W,
  parameter int DW = `FCD_DQ_W
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // flash pins
  output logic [AW-1:0] flash_addr_out,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [DW-1:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_byte_n_out,
  input wire logic flash_ready_busy_n_in
);

  typedef struct packed {
    fcd_pkg::fcd_st_t st;
    logic [2:0] idx;
    logic issued;
    logic [3:0] op;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic byte_mode;
    logic fail;
    logic start;
    logic start_wr;
    logic [AW-1:0] start_addr;
    logic [DW-1:0] start_data;
    logic wreq;
    logic [31:0] rd;
    logic byte_n;
  } fcd_host_t;

  fcd_host_t r_reg;
  fcd_host_t r_next;

  logic cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic [DW-1:0] dq_sync;
  logic rb_sync;

  // unlock address for the first or second unlock cycle
  function automatic logic [AW-1:0] unlock_addr(input logic byte_m,
                                                input logic second);
    if (second) begin
      unlock_addr = byte_m ? AW'(`FCD_UA2_BYTE) : AW'(`FCD_UA2_WORD);
    end else begin
      unlock_addr = byte_m ? AW'(`FCD_UA1_BYTE) : AW'(`FCD_UA1_WORD);
    end
  endfunction : unlock_addr

  // bus step idx of operation op; valid low past the last step
  function automatic fcd_pkg::fcd_step_t step_of(input logic [3:0] op,
      input logic [2:0] idx, input logic byte_m,
      input logic [AW-1:0] tgt, input logic [7:0] val);
    fcd_pkg::fcd_step_t s;
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    s = '{valid: 1'b1, wr: 1'b1, addr: '0, data: 8'h00};
    u1 = unlock_addr(byte_m, 1'b0);
    u2 = unlock_addr(byte_m, 1'b1);
    // unlock prefix shared by the identity, program, bypass entry and erase sequences
    if (idx == 3'h0 || idx == 3'h3) begin
      s.addr = u1;
      s.data = `FCD_CMD_UNLOCK1;
    end else begin
      s.addr = u2;
      s.data = `FCD_CMD_UNLOCK2;
    end
    case (op)
      `FCD_OP_READ: begin
        s = '{valid: (idx == 3'h0), wr: 1'b0, addr: tgt, data: 8'h00};
      end
      `FCD_OP_RESET: begin
        s = '{valid: (idx == 3'h0), wr: 1'b1, addr: '0,
              data: `FCD_CMD_RESET};
      end
      `FCD_OP_IDENT: begin
        s.valid = (idx <= 3'h3);
        if (idx == 3'h2) begin
          s = '{valid: 1'b1, wr: 1'b1, addr: u1, data: `FCD_CMD_IDENT};
        end else if (idx == 3'h3) begin
          s = '{valid: 1'b1, wr: 1'b0, addr: tgt, data: 8'h00};
        end
      end
      `FCD_OP_PROG: begin
        s.valid = (idx <= 3'h3);
        if (idx == 3'h2) begin
          s = '{valid: 1'b1, wr: 1'b1, addr: u1, data: `FCD_CMD_PROGRAM};
        end else if (idx == 3'h3) begin
          s = '{valid: 1'b1, wr: 1'b1, addr: tgt, data: val};
        end
      end
      `FCD_OP_BYP_ENTER: begin
        s.valid = (idx <= 3'h2);
        if (idx == 3'h2) begin
          s = '{valid: 1'b1, wr: 1'b1, addr: u1, data: `FCD_CMD_BYPASS};
        end
      end
      `FCD_OP_BYP_PROG: begin
        s = '{valid: (idx <= 3'h1), wr: 1'b1, addr: '0,
              data: `FCD_CMD_PROGRAM};
        if (idx == 3'h1) begin
          s.addr = tgt;
          s.data = val;
        end
      end
      `FCD_OP_BYP_EXIT: begin
        s = '{valid: (idx <= 3'h1), wr: 1'b1, addr: '0,
              data: (idx == 3'h0) ? `FCD_CMD_IDENT : `FCD_CMD_BYP_EXIT2};
      end
      `FCD_OP_CHIP_ERASE, `FCD_OP_SECT_ERASE: begin
        s.valid = (idx <= 3'h5);
        if (idx == 3'h2) begin
          s.addr = u1;
          s.data = `FCD_CMD_ERASE_SETUP;
        end else if (idx == 3'h5) begin
          s.addr = (op == `FCD_OP_CHIP_ERASE) ? u1 : tgt;
          s.data = (op == `FCD_OP_CHIP_ERASE) ? `FCD_CMD_CHIP
                                               : `FCD_CMD_SECTOR;
        end
      end
      `FCD_OP_SUSPEND: begin
        s = '{valid: (idx == 3'h0), wr: 1'b1, addr: '0,
              data: `FCD_CMD_SUSPEND};
      end
      `FCD_OP_RESUME: begin
        s = '{valid: (idx == 3'h0), wr: 1'b1, addr: '0,
              data: `FCD_CMD_RESUME};
      end
      default: begin
        s.valid = 1'b0;
      end
    endcase
    step_of = s;
  endfunction : step_of

  // operations that start an embedded algorithm and must be polled
  function automatic logic needs_poll(input logic [3:0] op);
    needs_poll = (op == `FCD_OP_PROG) || (op == `FCD_OP_BYP_PROG) ||
                 (op == `FCD_OP_CHIP_ERASE) || (op == `FCD_OP_SECT_ERASE);
  endfunction : needs_poll

  // true value of the poll bit once the algorithm has finished
  function automatic logic poll_done(input logic [3:0] op,
                                     input logic [DW-1:0] wd,
                                     input logic [DW-1:0] rd);
    logic want;
    want = (op == `FCD_OP_PROG || op == `FCD_OP_BYP_PROG) ?
           wd[`FCD_POLL_BIT] : 1'b1;
    poll_done = (rd[`FCD_POLL_BIT] == want);
  endfunction : poll_done

  // pin inputs pass two flops before any logic reads them
  fcd_sync #(
    .W(DW + 1)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in({flash_ready_busy_n_in, flash_dq_in}),
    .q_out({rb_sync, dq_sync})
  );

  fcd_pin_cycle #(
    .AW(AW),
    .DW(DW)
  ) u_cycle (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(r_reg.start),
    .write_in(r_reg.start_wr),
    .addr_in(r_reg.start_addr),
    .data_in(r_reg.start_data),
    .dq_sync_in(dq_sync),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out)
  );

  // sequencer and register file
  always_comb begin
    fcd_pkg::fcd_step_t s;
    logic busy;
    logic take_wr;
    s = step_of(r_reg.op, r_reg.idx, r_reg.byte_mode, r_reg.addr,
                r_reg.wdata[7:0]);
    r_next = r_reg;
    r_next.start = 1'b0;
    busy = (r_reg.st != fcd_pkg::ST_IDLE);
    take_wr = avs_write_in && !r_reg.wreq;
    // one wait cycle per access: ack on the cycle after the request
    r_next.wreq = !((avs_read_in || avs_write_in) && r_reg.wreq);
    if ((avs_read_in || avs_write_in) && r_reg.wreq) begin
      case (avs_address_in[4:2])
        `FCD_REG_CTRL: r_next.rd = {28'h0000000, r_reg.op};
        `FCD_REG_ADDR: r_next.rd = 32'(r_reg.addr);
        `FCD_REG_DATA: r_next.rd = 32'(r_reg.rdata);
        `FCD_REG_STAT: r_next.rd = {26'h0000000,
            r_reg.rdata[`FCD_WINDOW_BIT],
            r_reg.rdata[`FCD_FAIL_BIT],
            r_reg.rdata[`FCD_TOGGLE_BIT],
            !rb_sync, r_reg.fail, busy};
        `FCD_REG_CFG: r_next.rd = {31'h00000000, r_reg.byte_mode};
        default: r_next.rd = 32'h00000000;
      endcase
    end
    // software writes; a new operation is refused while one runs
    if (take_wr && !busy) begin
      case (avs_address_in[4:2])
        `FCD_REG_CTRL: begin
          r_next.op = avs_writedata_in[3:0];
          r_next.st = fcd_pkg::ST_SEQ;
          r_next.idx = 3'h0;
          r_next.issued = 1'b0;
          r_next.fail = 1'b0;
        end
        `FCD_REG_ADDR: r_next.addr = avs_writedata_in[AW-1:0];
        `FCD_REG_DATA: r_next.wdata = avs_writedata_in[DW-1:0];
        `FCD_REG_CFG: begin
          r_next.byte_mode = avs_writedata_in[0];
          r_next.byte_n = !avs_writedata_in[0];
        end
        default: begin
        end
      endcase
    end
    case (r_reg.st)
      fcd_pkg::ST_IDLE: begin
      end
      fcd_pkg::ST_SEQ: begin
        if (!s.valid) begin
          r_next.st = needs_poll(r_reg.op) ? fcd_pkg::ST_POLL
                                           : fcd_pkg::ST_IDLE;
          r_next.issued = 1'b0;
        end else if (!r_reg.issued) begin
          r_next.start = 1'b1;
          r_next.issued = 1'b1;
          r_next.start_wr = s.wr;
          r_next.start_addr = s.addr;
          r_next.start_data = DW'(s.data); // upper byte zero
          if ((r_reg.op == `FCD_OP_PROG && r_reg.idx == 3'h3) ||
              (r_reg.op == `FCD_OP_BYP_PROG && r_reg.idx == 3'h1)) begin
            r_next.start_data = r_reg.wdata; // full word value
          end
        end else if (cyc_done) begin
          r_next.issued = 1'b0;
          r_next.idx = r_reg.idx + 3'h1;
          if (!r_reg.start_wr) begin
            r_next.rdata = cyc_rdata;
          end
        end
      end
      fcd_pkg::ST_POLL, fcd_pkg::ST_REPOLL, fcd_pkg::ST_FINAL: begin
        // poll at the target or sector address
        if (!r_reg.issued) begin
          r_next.start = 1'b1;
          r_next.issued = 1'b1;
          r_next.start_wr = 1'b0;
          r_next.start_addr = r_reg.addr;
        end else if (cyc_done) begin
          r_next.issued = 1'b0;
          r_next.rdata = cyc_rdata;
          if (r_reg.st == fcd_pkg::ST_FINAL) begin
            r_next.st = fcd_pkg::ST_IDLE;
          end else if (poll_done(r_reg.op, r_reg.wdata, cyc_rdata)) begin
            r_next.st = fcd_pkg::ST_FINAL; // one more read
          end else if (r_reg.st == fcd_pkg::ST_REPOLL) begin
            r_next.st = fcd_pkg::ST_ABORT;
          end else if (cyc_rdata[`FCD_FAIL_BIT]) begin
            r_next.st = fcd_pkg::ST_REPOLL; // bit 7 may move with bit 5
          end
        end
      end
      fcd_pkg::ST_ABORT: begin
        // failed operation: reset the flash to array reading
        if (!r_reg.issued) begin
          r_next.start = 1'b1;
          r_next.issued = 1'b1;
          r_next.start_wr = 1'b1;
          r_next.start_addr = '0;
          r_next.start_data = DW'(`FCD_CMD_RESET);
        end else if (cyc_done) begin
          r_next.issued = 1'b0;
          r_next.fail = 1'b1;
          r_next.st = fcd_pkg::ST_IDLE;
        end
      end
      default: begin
        r_next.st = fcd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r_reg <= '{st: fcd_pkg::ST_IDLE, idx: 3'h0, issued: 1'b0, op: 4'h0,
                 addr: '0, wdata: '0, rdata: '0, byte_mode: 1'b0,
                 fail: 1'b0, start: 1'b0, start_wr: 1'b0, start_addr: '0,
                 start_data: '0, wreq: 1'b1, rd: 32'h00000000,
                 byte_n: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata_out = r_reg.rd;
  assign avs_waitrequest_out = r_reg.wreq;
  assign flash_byte_n_out = r_reg.byte_n;

endmodule : fcd_flash_host

// file: fcd_host_chk_sva.sv
// fcd_host_chk_sva.sv: bus and pin timing checks for the flash host.
// Assumes it is bound into fcd_flash_host by the statement at its foot.
`timescale 1ns/10ps

module fcd_host_chk #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // software bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // flash pins
  input wire logic [AW-1:0] flash_addr_out,
  input wire logic [DW-1:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_ack_next: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("late ack");
  a_ack_once: assert property (!avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("long ack");
  a_we_pulse: assert property ($fell(flash_we_n_out)
    |-> !flash_we_n_out [*8] ##1 flash_we_n_out) else $error("we width");
  a_we_in_ce: assert property (!flash_we_n_out |-> !flash_ce_n_out &&
    flash_dq_oe_out && flash_oe_n_out) else $error("bad write cycle");
  a_rd_no_dq: assert property (!flash_oe_n_out |-> !flash_ce_n_out &&
    !flash_dq_oe_out && flash_we_n_out) else $error("bad read cycle");
  a_ce_first: assert property ($fell(flash_we_n_out)
    |-> $past(flash_ce_n_out) == 1'b0) else $error("ce after we");
  a_we_rise: assert property ($rose(flash_we_n_out)
    |-> !flash_ce_n_out) else $error("ce rose first");
  a_pin_hold: assert property (!flash_ce_n_out &&
    $past(flash_ce_n_out) == 1'b0 |-> $stable(flash_addr_out) &&
    $stable(flash_dq_out)) else $error("pins moved");
  a_ce_gap: assert property ($rose(flash_ce_n_out)
    |-> flash_ce_n_out [*2]) else $error("short gap");
  // main traffic seen at least once
  cover property ($fell(flash_we_n_out));
  cover property ($fell(flash_oe_n_out));
  cover property (avs_write_in && !avs_waitrequest_out);
endmodule : fcd_host_chk

bind fcd_flash_host fcd_host_chk #(.AW(AW), .DW(DW)) u_chk (.clk_sys_in,
  .rst_n_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_ce_n_out,
  .flash_we_n_out, .flash_oe_n_out);

// file: fcd_flash_model.sv
// fcd_flash_model.sv: behavioural flash on the far side of the host pins.
// Assumes ce_n is low around every we_n and oe_n pulse of the host.
`timescale 1ns/10ps

module fcd_flash_model #(
  parameter logic [7:0] MAKER = 8'hc5, // arbitrary maker value
  parameter int BUSY_RD = 3
) (
  // host driven pins
  input wire logic [19:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic byte_n_in,
  // device driven pins
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  logic [15:0] mem [256];
  logic [15:0] pv, rd = '0;
  logic [19:0] la;
  logic [7:0] ld, ea;
  logic tog = 0, idm = 0, byp = 0, sus = 0, fl = 0, hit = 0;
  int n = 0, pc = 0, ec = 0, nw = 0;

  initial foreach (mem[i]) mem[i] = 16'hffff;
  // released bus shows the inverse of the last value, never a stale one
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
  assign ready_busy_n_out = !(pc > 0 || (ec > 0 && !sus));

  // write decoder; unlock and command decode use address bits 10:0 and data bits 7:0
  task automatic take(input logic [19:0] a, input logic [15:0] d);
    logic [10:0] u1, u2;
    logic h1;
    u1 = byte_n_in ? 11'h555 : 11'haaa;
    u2 = byte_n_in ? 11'h2aa : 11'h555;
    h1 = (a[10:0] == u1);
    nw++;
    ld = d[7:0];
    if (pc > 0 && !(fl && d[7:0] == 8'hf0)) return; // reset ends a fail
    if (ec > 0 && !sus) begin
      sus = (d[7:0] == 8'hb0);
      return;
    end
    if (sus && n == 0 && d[7:0] == 8'h30) begin
      sus = 1'b0;
      return;
    end
    if (d[7:0] == 8'hf0) begin
      idm = 1'b0;
      fl = 1'b0;
      pc = 0;
      n = 0;
      return;
    end
    if (byp && n == 0) begin
      n = (d[7:0] == 8'ha0) ? 9 : (d[7:0] == 8'h90) ? 8 : 0;
      return;
    end
    if (n == 8) begin
      byp = (d[7:0] != 8'h00);
      n = 0;
      return;
    end
    case (n)
      0, 3: n = (h1 && d[7:0] == 8'haa) ? n + 1 : 0;
      1, 4: n = (a[10:0] == u2 && d[7:0] == 8'h55) ? n + 1 : 0;
      2: begin
        idm = h1 && d[7:0] == 8'h90;
        byp = h1 && d[7:0] == 8'h20;
        n = !h1 ? 0 : d[7:0] == 8'ha0 ? 9 : d[7:0] == 8'h80 ? 3 : 0;
      end
      5: begin
        ec = (d[7:0] == 8'h30 || (h1 && d[7:0] == 8'h10)) ? BUSY_RD : 0;
        hit = d[7:0] == 8'h10 || a[18:12] == 7'h00; // only sector 0
        n = 0;
      end
      default: begin
        {pv, ea} = {d, a[7:0]};
        pc = BUSY_RD;
        fl = |(pv & ~mem[a[7:0]]); // raising a 0 never ends
        n = 0;
      end
    endcase
  endtask : take

  // address at the later falling edge, data at the earlier rising edge
  always @(negedge we_n_in) la = addr_in;
  always @(posedge we_n_in) if (!ce_n_in) take(la, dq_in);

  // each read shows status while an algorithm runs
  always @(negedge oe_n_in) #1 if (!ce_n_in) begin // pins settle first
    if (pc > 0) begin
      rd = {8'h00, ~pv[7], tog, fl, 5'h00};
      if (!fl) pc--;
      if (pc == 0) mem[ea] = pv;
    end else if (ec > 0 && !sus) begin
      rd = {8'h00, 1'b0, tog, 6'h08};
      ec--;
      if (ec == 0 && hit) foreach (mem[i]) mem[i] = 16'hffff;
    end else if (idm)
      rd = {8'h00, addr_in[7:0] == 8'h00 ? MAKER : 8'h00};
    else
      rd = mem[addr_in[7:0]];
    tog = ~tog;
  end
endmodule : fcd_flash_model

// file: tb.sv
// tb.sv: runs every host operation against the flash model.
// Assumes design, model and checker are compiled before it.
`timescale 1ns/10ps
`include "fcd_defines.svh"

`define CHK(x, y) begin n_checks++; if ((x) !== (y)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (x), (y)); end end

module tb;
  logic clk_sys_in = 0;
  logic rst_n_in = 0;
  logic [4:0] avs_address_in = '0;
  logic avs_read_in = 0;
  logic avs_write_in = 0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out, q;
  logic avs_waitrequest_out, flash_dq_oe_out, flash_byte_n_out;
  logic flash_ce_n_out, flash_we_n_out, flash_oe_n_out;
  logic flash_ready_busy_n_in;
  logic [19:0] flash_addr_out;
  logic [15:0] flash_dq_out, flash_dq_in, m_dq;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 clk_sys_in = ~clk_sys_in;
  // wire level: host drives during writes, the flash otherwise
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : m_dq;

  fcd_flash_host u_dut (.clk_sys_in, .rst_n_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_out,
    .flash_dq_in, .flash_ce_n_out, .flash_we_n_out, .flash_oe_n_out,
    .flash_byte_n_out, .flash_ready_busy_n_in);
  fcd_flash_model u_flash (.addr_in(flash_addr_out), .dq_in(flash_dq_in),
    .ce_n_in(flash_ce_n_out), .we_n_in(flash_we_n_out),
    .oe_n_in(flash_oe_n_out), .byte_n_in(flash_byte_n_out), .dq_out(m_dq),
    .ready_busy_n_out(flash_ready_busy_n_in));

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus

  // start an operation, wait until idle, check the flash-side writes;
  // only a failed program (four writes plus the reset) makes five
  task automatic op(input logic [3:0] c, input logic [19:0] a,
      input logic [15:0] v, input int w, input logic [7:0] l);
    int n0;
    n0 = u_flash.nw;
    bus(1'b1, 5'h04, {12'h000, a});
    bus(1'b1, 5'h08, {16'h0000, v});
    bus(1'b1, 5'h00, {28'h0000000, c});
    q = 32'h1;
    while (q[0] !== 1'b0) bus(1'b0, 5'h0c, 32'h0);
    `CHK(q[1], w == 5)
    `CHK(u_flash.nw - n0, w)
    if (w > 0) `CHK(u_flash.ld, l)
  endtask : op

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // hang guard, well above the 1200 or so cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      wrap_up;
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(1'b0, 5'h10, 32'h0);
    `CHK({q, flash_byte_n_out}, 33'h1)
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    `CHK(q, 32'h0)
    op(`FCD_OP_PROG, 20'h00003, 16'h1234, 4, 8'h34);
    `CHK(u_flash.mem[3], 16'h1234)
    op(`FCD_OP_IDENT, 20'h00000, 16'h0, 3, 8'h90);
    bus(1'b0, 5'h08, 32'h0);
    `CHK(q[7:0], u_flash.MAKER)
    op(`FCD_OP_RESET, 20'h0, 16'h0, 1, 8'hf0);
    op(`FCD_OP_READ, 20'h00003, 16'h0, 0, 8'h0);
    bus(1'b0, 5'h08, 32'h0);
    `CHK(q[15:0], 16'h1234)
    op(`FCD_OP_BYP_ENTER, 20'h0, 16'h0, 3, 8'h20);
    op(`FCD_OP_BYP_PROG, 20'h00005, 16'h00a5, 2, 8'ha5);
    op(`FCD_OP_BYP_EXIT, 20'h0, 16'h0, 2, 8'h00);
    `CHK({u_flash.byp, u_flash.mem[5]}, 17'h000a5)
    op(`FCD_OP_SECT_ERASE, 20'h00003, 16'h0, 6, 8'h30);
    `CHK(u_flash.mem[3], 16'hffff)
    op(`FCD_OP_CHIP_ERASE, 20'h0, 16'h0, 6, 8'h10);
    op(`FCD_OP_SUSPEND, 20'h0, 16'h0, 1, 8'hb0);
    op(`FCD_OP_RESUME, 20'h0, 16'h0, 1, 8'h30);
    bus(1'b1, 5'h10, 32'h1);
    `CHK(flash_byte_n_out, 1'b0)
    op(`FCD_OP_PROG, 20'h00007, 16'h0033, 4, 8'h33);
    `CHK(u_flash.mem[7][7:0], 8'h33)
    op(`FCD_OP_PROG, 20'h00007, 16'h00ff, 5, 8'hf0);
    `CHK(u_flash.mem[7][7:0], 8'h33)
    wrap_up;
  end
endmodule : tb
